/* dv/uart_line_model.sv */
`timescale 1ns/1ps
module uart_line_model #(
   parameter int BIT_CYC = 8
) (
   input  wire logic sys_clk,
   output logic      line
);
   initial line = 1'h1;

   // One bit time on the line
   task automatic drive(input logic b);
      @(posedge sys_clk);
      line <= b;
      repeat (BIT_CYC - 1) @(posedge sys_clk);
   endtask

   // Whole frame, LSB first, line back to idle high after the stop bit
   task automatic send(input logic [7:0] d, input logic par_en, par_odd, bad_par, bad_stop, input int gap);
      repeat (gap) @(posedge sys_clk);
      drive(1'h0);
      for (int i = 0; i < 8; i++) begin
         drive(d[i]);
      end
      if (par_en) begin
         drive(^d ^ par_odd ^ bad_par);
      end
      drive(~bad_stop);
      if (bad_stop) begin
         drive(1'h1);
      end
   endtask

   // Low glitch far shorter than half a bit
   task automatic pulse();
      @(posedge sys_clk);
      line <= 1'h0;
      @(posedge sys_clk);
      line <= 1'h1;
   endtask
endmodule

/* dv/uart_snooze_receive_tb_top.sv */
`timescale 1ns/1ps
module uart_snooze_receive_tb_top;
   localparam int BIT = 8;
   logic        sys_clk = 1'h0;
   logic        rst = 1'h1;
   logic        deep_sleep = 1'h0;
   logic        line_w;
   logic        snooze_state, clock_request, done_irq, err_irq;
   logic [7:0]  awaddr = 8'h00;
   logic [7:0]  araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0]  wstrb = 4'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic        awready, wready, bvalid, arready, rvalid;
   logic [1:0]  bresp, rresp, rsp;
   logic [31:0] rdata, v;
   logic [31:0] lfsr = 32'h848a;
   logic [7:0]  b;
   logic [7:0]  q[$];
   int          fail_count = 0, checks_done = 0, n_done = 0, n_err = 0, d0, e0;
   bit          saw_busy, saw_snz;

   // Core clock stands for the fast internal oscillator source
   always #20 sys_clk = ~sys_clk;

   uart_line_model #(.BIT_CYC(BIT)) tx_u (.sys_clk(sys_clk), .line(line_w));

   uart_snooze_receive dut_u (
      .sys_clk(sys_clk), .rst(rst), .serial_rx_pin(line_w), .deep_sleep(deep_sleep),
      .snooze_state(snooze_state), .clock_request(clock_request),
      .receive_complete_irq(done_irq), .receive_error_irq(err_irq),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   always @(posedge sys_clk) begin
      if (done_irq === 1'h1) n_done++;
      if (err_irq === 1'h1) n_err++;
      if (clock_request === 1'h1) saw_busy = 1;
      if (snooze_state === 1'h1) saw_snz = 1;
   end

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (awvalid && awready === 1'h1) awvalid <= 1'h0;
         if (wvalid && wready === 1'h1) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      bready <= 1'h0;
      rsp = bresp;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge sys_clk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge sys_clk);
         if (arvalid && arready === 1'h1) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      rready <= 1'h0;
      v = rdata;
      rsp = rresp;
   endtask

   // Random byte, frame sent, then settle time for the flags
   task automatic frame(input logic pe, po, bp, bs);
      lfsr = lfsr_next(lfsr);
      b = lfsr[7:0];
      d0 = n_done;
      e0 = n_err;
      tx_u.send(b, pe, po, bp, bs, int'(lfsr[11:8]));
      repeat (6) @(posedge sys_clk);
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      fail_count++;
      final_report();
   end

   initial begin
      repeat (2) @(posedge sys_clk);
      rst <= 1'h0;
      axr(uart_snooze_pkg::OFF_CTRL);
      chk(v, 32'h0);
      axr(uart_snooze_pkg::OFF_BAUD);
      chk(v, 32'hd9);
      axr(8'h10);
      chk(v, 32'h0);
      chk(rsp, uart_snooze_pkg::RESP_SLVERR);
      axw(8'h20, 32'h1);
      chk(rsp, uart_snooze_pkg::RESP_SLVERR);
      axw(uart_snooze_pkg::OFF_BAUD, BIT);
      axw(uart_snooze_pkg::OFF_CTRL, 32'h1);
      // Deep sleep without sleep receive: frame ignored
      deep_sleep <= 1'h1;
      frame(1'h0, 1'h0, 1'h0, 1'h0);
      chk(n_done - d0, 0);
      axr(uart_snooze_pkg::OFF_STATUS);
      chk(v[uart_snooze_pkg::ST_AVAIL], 1'h0);
      // Sleep receive: no bus traffic during the frame
      axw(uart_snooze_pkg::OFF_CTRL, 32'h3);
      saw_busy = 0;
      saw_snz = 0;
      frame(1'h0, 1'h0, 1'h0, 1'h0);
      chk(saw_snz, 1);
      chk(saw_busy, 1);
      chk(n_done - d0, 1);
      deep_sleep <= 1'h0;
      repeat (3) @(posedge sys_clk);
      chk(snooze_state, 1'h0);
      axr(uart_snooze_pkg::OFF_RXDATA);
      chk(v, {24'h0, b});
      // Glitch in deep sleep: no transfer, snooze kept
      deep_sleep <= 1'h1;
      d0 = n_done;
      tx_u.pulse();
      repeat (30) @(posedge sys_clk);
      chk({snooze_state, 8'(n_done - d0)}, {1'h1, 8'h0});
      // Suppressed framing error in snooze
      axw(uart_snooze_pkg::OFF_STATUS, 32'h7);
      axr(uart_snooze_pkg::OFF_RXDATA);
      axw(uart_snooze_pkg::OFF_CTRL, 32'h7);
      frame(1'h0, 1'h0, 1'h0, 1'h1);
      chk(n_err - e0, 0);
      axr(uart_snooze_pkg::OFF_STATUS);
      chk(v[2:0], 3'h0);
      chk(v[uart_snooze_pkg::ST_SNOOZE], 1'h1);
      deep_sleep <= 1'h0;
      axr(uart_snooze_pkg::OFF_RXDATA);
      chk(v, {24'h0, b});
      // Awake errors: both parity senses, good and bad, then bad stop
      for (int i = 0; i < 5; i++) begin
         axw(uart_snooze_pkg::OFF_CTRL, 32'h9 | (32'(i & 1) << 4));
         frame(1'h1, i[0], i[1] && i < 4, i == 4);
         axr(uart_snooze_pkg::OFF_STATUS);
         chk(v[2:0], (i == 4) ? 3'h2 : {2'h0, i[1]});
         chk(n_err - e0, (i == 4 || i[1]) ? 1 : 0);
         axw(uart_snooze_pkg::OFF_STATUS, 32'h7);
         axr(uart_snooze_pkg::OFF_RXDATA);
         if (i < 2) chk(v, {24'h0, b});
      end
      // Framing error in the cycle of a flag clear: the set wins
      axw(uart_snooze_pkg::OFF_CTRL, 32'h1);
      axr(uart_snooze_pkg::OFF_RXDATA);
      fork
         tx_u.send(8'h55, 1'h0, 1'h0, 1'h0, 1'h1, 0);
         begin
            repeat (10 * BIT - 2) @(posedge sys_clk);
            axw(uart_snooze_pkg::OFF_STATUS, 32'h7);
         end
      join
      axr(uart_snooze_pkg::OFF_STATUS);
      chk(v[2:0], 3'h2);
      axw(uart_snooze_pkg::OFF_STATUS, 32'h7);
      axr(uart_snooze_pkg::OFF_RXDATA);
      chk(v, 32'h55);
      // Fill the buffer past full, then drain it
      d0 = n_done;
      e0 = n_err;
      for (int i = 0; i < 17; i++) begin
         lfsr = lfsr_next(lfsr);
         if (i < 16) q.push_back(lfsr[7:0]);
         tx_u.send(lfsr[7:0], 1'h0, 1'h0, 1'h0, 1'h0, 0);
      end
      repeat (6) @(posedge sys_clk);
      chk(n_done - d0, 16);
      chk(n_err - e0, 1);
      axr(uart_snooze_pkg::OFF_STATUS);
      chk(v[uart_snooze_pkg::ST_OVR], 1'h1);
      while (q.size() > 0) begin
         axr(uart_snooze_pkg::OFF_RXDATA);
         chk(v, {24'h0, q.pop_front()});
      end
      axr(uart_snooze_pkg::OFF_RXDATA);
      chk(v, 32'h0);
      final_report();
   end
endmodule

/* rtl/rx_fifo.sv */
`timescale 1ns/1ps
module rx_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input  wire logic             sys_clk,
   input  wire logic             rst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [WIDTH-1:0] mem_nxt [DEPTH];
   logic [AW-1:0]    wr_ptr_r, wr_ptr_nxt;
   logic [AW-1:0]    rd_ptr_r, rd_ptr_nxt;
   logic [AW:0]      count_r, count_nxt;
   logic             push;
   logic             pop;

   always_comb begin
      push       = in_valid && in_ready;
      pop        = out_valid && out_ready;
      mem_nxt    = mem_r;
      wr_ptr_nxt = wr_ptr_r;
      rd_ptr_nxt = rd_ptr_r;
      count_nxt  = count_r;
      if (push) begin
         mem_nxt[wr_ptr_r] = in_data;
         wr_ptr_nxt        = (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
         rd_ptr_nxt = (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
         count_nxt = count_r + 1'b1;
      end else if (pop && !push) begin
         count_nxt = count_r - 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      mem_r <= mem_nxt;
      if (rst) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
      end else begin
         wr_ptr_r <= wr_ptr_nxt;
         rd_ptr_r <= rd_ptr_nxt;
         count_r  <= count_nxt;
      end
   end

   assign in_ready  = (count_r != (AW+1)'(DEPTH));
   assign out_valid = (count_r != '0);
   assign out_data  = mem_r[rd_ptr_r];
endmodule

/* rtl/uart_snooze_pkg.sv */
package uart_snooze_pkg;
   // Clock and line rate
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned BAUD_RATE     = 115_200;
   localparam logic [15:0] BAUD_DIV_RST  = 16'(CLK_HZ / BAUD_RATE);

   // Register byte offsets
   localparam logic [7:0] OFF_CTRL   = 8'h00;
   localparam logic [7:0] OFF_BAUD   = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_RXDATA = 8'h0c;

   // Control fields
   localparam int CTRL_RX_EN   = 0;
   localparam int CTRL_SLP_EN  = 1;
   localparam int CTRL_SUPPR   = 2;
   localparam int CTRL_PAR_EN  = 3;
   localparam int CTRL_PAR_ODD = 4;
   localparam int CTRL_W       = 5;
   localparam logic [4:0] CTRL_RST = 5'h00;

   // Status fields
   localparam int ST_PE     = 0;
   localparam int ST_FE     = 1;
   localparam int ST_OVR    = 2;
   localparam int ST_AVAIL  = 3;
   localparam int ST_SNOOZE = 4;
   localparam int ST_BUSY   = 5;

   localparam int DATA_BITS  = 8;
   localparam int FIFO_DEPTH = 16;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_PARITY, RX_STOP} rx_state_t;
endpackage

/* rtl/uart_snooze_receive.sv */
`timescale 1ns/1ps
module uart_snooze_receive #(
   parameter int ADDR_W = 8
) (
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              serial_rx_pin,
   input  wire logic              deep_sleep,
   output logic                   snooze_state,
   output logic                   clock_request,
   output logic                   receive_complete_irq,
   output logic                   receive_error_irq,
   input  wire logic [ADDR_W-1:0] s_axi_awaddr,
   input  wire logic              s_axi_awvalid,
   output logic                   s_axi_awready,
   input  wire logic [31:0]       s_axi_wdata,
   input  wire logic [3:0]        s_axi_wstrb,
   input  wire logic              s_axi_wvalid,
   output logic                   s_axi_wready,
   output logic [1:0]             s_axi_bresp,
   output logic                   s_axi_bvalid,
   input  wire logic              s_axi_bready,
   input  wire logic [ADDR_W-1:0] s_axi_araddr,
   input  wire logic              s_axi_arvalid,
   output logic                   s_axi_arready,
   output logic [31:0]            s_axi_rdata,
   output logic [1:0]             s_axi_rresp,
   output logic                   s_axi_rvalid,
   input  wire logic              s_axi_rready
);
   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
      hit = (8'(a) == off);
   endfunction

   // Line synchroniser and edge detect
   logic rx_meta_r, rx_sync_r, rx_prev_r;
   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_meta_r <= 1'b1;
         rx_sync_r <= 1'b1;
         rx_prev_r <= 1'b1;
      end else begin
         rx_meta_r <= serial_rx_pin;
         rx_sync_r <= rx_meta_r;
         rx_prev_r <= rx_sync_r;
      end
   end
   logic start_edge;
   assign start_edge = rx_prev_r && !rx_sync_r;

   // Software state
   logic [uart_snooze_pkg::CTRL_W-1:0] ctrl_r, ctrl_nxt;
   logic [15:0] baud_r, baud_nxt;
   logic        pe_r, pe_nxt, fe_r, fe_nxt, ovr_r, ovr_nxt;
   logic        rx_en, slp_en, suppr, par_en, par_odd;
   assign rx_en   = ctrl_r[uart_snooze_pkg::CTRL_RX_EN];
   assign slp_en  = ctrl_r[uart_snooze_pkg::CTRL_SLP_EN];
   assign suppr   = ctrl_r[uart_snooze_pkg::CTRL_SUPPR];
   assign par_en  = ctrl_r[uart_snooze_pkg::CTRL_PAR_EN];
   assign par_odd = ctrl_r[uart_snooze_pkg::CTRL_PAR_ODD];

   // Receiver
   uart_snooze_pkg::rx_state_t rx_state_r, rx_state_nxt;
   logic [15:0] baud_cnt_r, baud_cnt_nxt;
   logic [2:0]  bit_cnt_r, bit_cnt_nxt;
   logic [7:0]  shift_r, shift_nxt;
   logic        par_bad_r, par_bad_nxt;
   logic        snooze_r, snooze_nxt;
   logic        rx_active, tick, done, frame_err, fifo_in_ready, suppress_now;

   assign rx_active    = rx_en && (!deep_sleep || slp_en);
   assign tick         = (baud_cnt_r == '0);
   assign done         = (rx_state_r == uart_snooze_pkg::RX_STOP) && tick && rx_active;
   assign frame_err    = !rx_sync_r;
   assign suppress_now = suppr && snooze_r;

   always_comb begin
      rx_state_nxt = rx_state_r;
      baud_cnt_nxt = tick ? baud_cnt_r : baud_cnt_r - 1'b1;
      bit_cnt_nxt  = bit_cnt_r;
      shift_nxt    = shift_r;
      par_bad_nxt  = par_bad_r;
      case (rx_state_r)
         uart_snooze_pkg::RX_IDLE: begin
            par_bad_nxt = 1'b0;
            if (rx_active && start_edge) begin
               rx_state_nxt = uart_snooze_pkg::RX_START;
               baud_cnt_nxt = baud_r >> 1;
            end
         end
         uart_snooze_pkg::RX_START: begin
            if (tick) begin
               baud_cnt_nxt = baud_r - 1'b1;
               bit_cnt_nxt  = '0;
               rx_state_nxt = rx_sync_r ? uart_snooze_pkg::RX_IDLE : uart_snooze_pkg::RX_DATA;
            end
         end
         uart_snooze_pkg::RX_DATA: begin
            if (tick) begin
               baud_cnt_nxt = baud_r - 1'b1;
               shift_nxt    = {rx_sync_r, shift_r[7:1]};
               bit_cnt_nxt  = bit_cnt_r + 1'b1;
               if (bit_cnt_r == 3'(uart_snooze_pkg::DATA_BITS - 1)) begin
                  rx_state_nxt = par_en ? uart_snooze_pkg::RX_PARITY : uart_snooze_pkg::RX_STOP;
               end
            end
         end
         uart_snooze_pkg::RX_PARITY: begin
            if (tick) begin
               baud_cnt_nxt = baud_r - 1'b1;
               par_bad_nxt  = ((^shift_r) ^ rx_sync_r) != par_odd;
               rx_state_nxt = uart_snooze_pkg::RX_STOP;
            end
         end
         uart_snooze_pkg::RX_STOP: begin
            if (tick) begin
               rx_state_nxt = uart_snooze_pkg::RX_IDLE;
            end
         end
         default: rx_state_nxt = uart_snooze_pkg::RX_IDLE;
      endcase
      if (!rx_active) begin
         rx_state_nxt = uart_snooze_pkg::RX_IDLE;
      end
   end

   // Snooze state entered on a line start edge in deep sleep, left when deep sleep ends
   always_comb begin
      snooze_nxt = snooze_r;
      if (!deep_sleep) begin
         snooze_nxt = 1'b0;
      end else if (slp_en && rx_en && rx_state_r == uart_snooze_pkg::RX_IDLE && start_edge) begin
         snooze_nxt = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         rx_state_r <= uart_snooze_pkg::RX_IDLE;
         baud_cnt_r <= '0;
         bit_cnt_r  <= '0;
         shift_r    <= '0;
         par_bad_r  <= 1'b0;
         snooze_r   <= 1'b0;
      end else begin
         rx_state_r <= rx_state_nxt;
         baud_cnt_r <= baud_cnt_nxt;
         bit_cnt_r  <= bit_cnt_nxt;
         shift_r    <= shift_nxt;
         par_bad_r  <= par_bad_nxt;
         snooze_r   <= snooze_nxt;
      end
   end

   // Received bytes queue
   logic       fifo_out_valid, pop;
   logic [7:0] fifo_out_data;
   rx_fifo #(
      .WIDTH (uart_snooze_pkg::DATA_BITS),
      .DEPTH (uart_snooze_pkg::FIFO_DEPTH)
   ) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (done),
      .in_ready  (fifo_in_ready),
      .in_data   (shift_r),
      .out_valid (fifo_out_valid),
      .out_ready (pop),
      .out_data  (fifo_out_data)
   );

   // Register bus
   logic              aw_full_r, aw_full_nxt, w_full_r, w_full_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic [31:0]       w_data_r, w_data_nxt;
   logic [3:0]        w_strb_r, w_strb_nxt;
   logic              awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
   logic [1:0]        bresp_nxt, rresp_nxt;
   logic [31:0]       rdata_nxt;
   logic              do_write, clr_pe, clr_fe, clr_ovr;
   logic              cmp_irq_nxt, err_irq_nxt, clk_req_nxt;

   always_comb begin
      aw_full_nxt = aw_full_r;
      w_full_nxt  = w_full_r;
      aw_addr_nxt = aw_addr_r;
      w_data_nxt  = w_data_r;
      w_strb_nxt  = w_strb_r;
      bvalid_nxt  = s_axi_bvalid;
      bresp_nxt   = s_axi_bresp;
      rvalid_nxt  = s_axi_rvalid;
      rresp_nxt   = s_axi_rresp;
      rdata_nxt   = s_axi_rdata;
      arready_nxt = s_axi_arready;
      ctrl_nxt    = ctrl_r;
      baud_nxt    = baud_r;
      pop         = 1'b0;
      clr_pe      = 1'b0;
      clr_fe      = 1'b0;
      clr_ovr     = 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_full_nxt = 1'b1;
         aw_addr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_full_nxt = 1'b1;
         w_data_nxt = s_axi_wdata;
         w_strb_nxt = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      do_write = aw_full_r && w_full_r && !s_axi_bvalid;
      if (do_write) begin
         aw_full_nxt = 1'b0;
         w_full_nxt  = 1'b0;
         bvalid_nxt  = 1'b1;
         bresp_nxt   = uart_snooze_pkg::RESP_OKAY;
         if (hit(aw_addr_r, uart_snooze_pkg::OFF_CTRL)) begin
            if (w_strb_r[0]) ctrl_nxt = w_data_r[uart_snooze_pkg::CTRL_W-1:0];
         end else if (hit(aw_addr_r, uart_snooze_pkg::OFF_BAUD)) begin
            if (w_strb_r[0]) baud_nxt[7:0] = w_data_r[7:0];
            if (w_strb_r[1]) baud_nxt[15:8] = w_data_r[15:8];
         end else if (hit(aw_addr_r, uart_snooze_pkg::OFF_STATUS)) begin
            clr_pe  = w_strb_r[0] && w_data_r[uart_snooze_pkg::ST_PE];
            clr_fe  = w_strb_r[0] && w_data_r[uart_snooze_pkg::ST_FE];
            clr_ovr = w_strb_r[0] && w_data_r[uart_snooze_pkg::ST_OVR];
         end else if (!hit(aw_addr_r, uart_snooze_pkg::OFF_RXDATA)) begin
            bresp_nxt = uart_snooze_pkg::RESP_SLVERR;
         end
      end
      awready_nxt = !aw_full_nxt && !bvalid_nxt;
      wready_nxt  = !w_full_nxt && !bvalid_nxt;
      if (s_axi_rvalid && s_axi_rready) begin
         rvalid_nxt  = 1'b0;
         arready_nxt = 1'b1;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         arready_nxt = 1'b0;
         rvalid_nxt  = 1'b1;
         rresp_nxt   = uart_snooze_pkg::RESP_OKAY;
         rdata_nxt   = '0;
         if (hit(s_axi_araddr, uart_snooze_pkg::OFF_CTRL)) begin
            rdata_nxt[uart_snooze_pkg::CTRL_W-1:0] = ctrl_r;
         end else if (hit(s_axi_araddr, uart_snooze_pkg::OFF_BAUD)) begin
            rdata_nxt[15:0] = baud_r;
         end else if (hit(s_axi_araddr, uart_snooze_pkg::OFF_STATUS)) begin
            rdata_nxt[uart_snooze_pkg::ST_PE]     = pe_r;
            rdata_nxt[uart_snooze_pkg::ST_FE]     = fe_r;
            rdata_nxt[uart_snooze_pkg::ST_OVR]    = ovr_r;
            rdata_nxt[uart_snooze_pkg::ST_AVAIL]  = fifo_out_valid;
            rdata_nxt[uart_snooze_pkg::ST_SNOOZE] = snooze_r;
            rdata_nxt[uart_snooze_pkg::ST_BUSY]   = rx_state_r != uart_snooze_pkg::RX_IDLE;
         end else if (hit(s_axi_araddr, uart_snooze_pkg::OFF_RXDATA)) begin
            rdata_nxt[7:0] = fifo_out_valid ? fifo_out_data : 8'h00;
            pop            = fifo_out_valid;
         end else begin
            rresp_nxt = uart_snooze_pkg::RESP_SLVERR;
         end
      end
      // Hardware set wins over software clear
      pe_nxt      = (pe_r && !clr_pe) || (done && par_bad_r && !suppress_now);
      fe_nxt      = (fe_r && !clr_fe) || (done && frame_err && !suppress_now);
      ovr_nxt     = (ovr_r && !clr_ovr) || (done && !fifo_in_ready && !suppress_now);
      err_irq_nxt = done && !suppress_now && (par_bad_r || frame_err || !fifo_in_ready);
      cmp_irq_nxt = done && fifo_in_ready;
      clk_req_nxt = rx_state_nxt != uart_snooze_pkg::RX_IDLE;
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         aw_full_r            <= 1'b0;
         w_full_r             <= 1'b0;
         aw_addr_r            <= '0;
         w_data_r             <= '0;
         w_strb_r             <= '0;
         s_axi_awready        <= 1'b1;
         s_axi_wready         <= 1'b1;
         s_axi_bvalid         <= 1'b0;
         s_axi_bresp          <= uart_snooze_pkg::RESP_OKAY;
         s_axi_arready        <= 1'b1;
         s_axi_rvalid         <= 1'b0;
         s_axi_rresp          <= uart_snooze_pkg::RESP_OKAY;
         s_axi_rdata          <= '0;
         ctrl_r               <= uart_snooze_pkg::CTRL_RST;
         baud_r               <= uart_snooze_pkg::BAUD_DIV_RST;
         pe_r                 <= 1'b0;
         fe_r                 <= 1'b0;
         ovr_r                <= 1'b0;
         receive_complete_irq <= 1'b0;
         receive_error_irq    <= 1'b0;
         clock_request        <= 1'b0;
         snooze_state         <= 1'b0;
      end else begin
         aw_full_r            <= aw_full_nxt;
         w_full_r             <= w_full_nxt;
         aw_addr_r            <= aw_addr_nxt;
         w_data_r             <= w_data_nxt;
         w_strb_r             <= w_strb_nxt;
         s_axi_awready        <= awready_nxt;
         s_axi_wready         <= wready_nxt;
         s_axi_bvalid         <= bvalid_nxt;
         s_axi_bresp          <= bresp_nxt;
         s_axi_arready        <= arready_nxt;
         s_axi_rvalid         <= rvalid_nxt;
         s_axi_rresp          <= rresp_nxt;
         s_axi_rdata          <= rdata_nxt;
         ctrl_r               <= ctrl_nxt;
         baud_r               <= baud_nxt;
         pe_r                 <= pe_nxt;
         fe_r                 <= fe_nxt;
         ovr_r                <= ovr_nxt;
         receive_complete_irq <= cmp_irq_nxt;
         receive_error_irq    <= err_irq_nxt;
         clock_request        <= clk_req_nxt;
         snooze_state         <= snooze_nxt;
      end
   end

   // Checks
   sequence seq_sleep_start;
      deep_sleep && slp_en && rx_en && rx_state_r == uart_snooze_pkg::RX_IDLE && start_edge;
   endsequence
   sequence seq_short_pulse;
      rx_state_r == uart_snooze_pkg::RX_START && tick && rx_sync_r && rx_active;
   endsequence

   a_sleep_halts: assert property (@(posedge sys_clk) disable iff (rst)
      deep_sleep && !slp_en |=> rx_state_r == uart_snooze_pkg::RX_IDLE)
      else $error("receiver active in deep sleep without sleep receive");
   a_snooze_entry: assert property (@(posedge sys_clk) disable iff (rst)
      seq_sleep_start |=> snooze_r ##1 snooze_state)
      else $error("snooze state not entered on line edge");
   a_sleep_receive: assert property (@(posedge sys_clk) disable iff (rst)
      seq_sleep_start |=> rx_state_r == uart_snooze_pkg::RX_START ##1 clock_request)
      else $error("sleep reception did not start");
   a_short_pulse: assert property (@(posedge sys_clk) disable iff (rst)
      seq_short_pulse ##0 deep_sleep |=> rx_state_r == uart_snooze_pkg::RX_IDLE && snooze_r == $past(snooze_r))
      else $error("short start pulse not dropped");
   a_error_hidden: assert property (@(posedge sys_clk) disable iff (rst)
      done && suppress_now |=> !receive_error_irq && !$rose(pe_r) && !$rose(fe_r) && !$rose(ovr_r))
      else $error("error reported while suppressed");
   a_complete_irq: assert property (@(posedge sys_clk) disable iff (rst)
      done && fifo_in_ready |=> receive_complete_irq ##1 !receive_complete_irq)
      else $error("receive complete interrupt missing");
   a_frame_steps: assert property (@(posedge sys_clk) disable iff (rst)
      rx_state_r == uart_snooze_pkg::RX_DATA && tick && rx_active
      && bit_cnt_r == 3'(uart_snooze_pkg::DATA_BITS - 1) && !par_en
      |=> rx_state_r == uart_snooze_pkg::RX_STOP)
      else $error("frame did not reach stop bit");
   a_set_wins: assert property (@(posedge sys_clk) disable iff (rst)
      done && frame_err && !suppress_now && clr_fe |=> fe_r)
      else $error("framing error lost to clear");
   a_overrun_flag: assert property (@(posedge sys_clk) disable iff (rst)
      done && !fifo_in_ready && !suppress_now |=> ovr_r && receive_error_irq)
      else $error("overrun not flagged");
endmodule
